// [logic/sdram_memory_end.sv]
// What this block does
// R1: Clock enable low suspends one cycle later.
// R2: Read mask floats outputs two cycles later.
// R3: Write mask blocks same-cycle input word.
// R4: Controller sends first write word with command.
// R5: Command taken on edge chip select active.
// R6: Precharge floats outputs CL cycles later.
// R7: Precharge last word at CL minus one.
// R8: Burst stop floats outputs CL cycles later.
// R9: Burst stop last word at CL minus one.
// R10: Read auto-precharge waits BL plus precharge.
// R11: Write auto-precharge waits BL+1 plus precharge.
// R12: Timings round up to whole cycles.
//
// Purpose: Memory end: command intake, read pipeline and masking.
// Assumes: Single storage word; burst addresses are not modelled.
// Notes:   casLatency is a static strap from the user side.
`timescale 1ns/100ps
`default_nettype none
module sdram_memory_end
  import sdram_lat_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [1:0]        casLatency,
  sdram_link_if.memory           link,
  output logic                   clockRunning,
  output logic [DATA_W-1:0]      storedWord,
  output logic                   burstActive
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic              clkRun;
    logic [DATA_W-1:0] mem;
    logic [3:0]        readLeft;
    logic [3:0]        issue;    // Unused; reset to RD_PIPE_RESET and never written.
    logic [3:0]        pipe;     // Pipe valid, bit k = k+1 cycles old.
    logic [1:0]        maskPipe;
    logic [DATA_W-1:0] dOut;
    logic              dOe;
    logic              writing;
    logic [3:0]        writeLeft;
  } mem_state_t;

  mem_state_t state;
  mem_state_t next_state;
  logic       cmdValid;
  logic       lastStage;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.clkRun = link.clkEnable; // see R1
    cmdValid = state.clkRun && !link.chipSelectN; // see R5
    if (state.clkRun) begin
      next_state.maskPipe = {state.maskPipe[0], link.dataMask}; // see R2
      // Word leaving the pipe lines up with CAS latency.
      next_state.pipe = {state.pipe[2:0], state.readLeft != 4'h0};
      if (state.readLeft != 4'h0) begin
        next_state.readLeft = state.readLeft - 4'h1;
      end
      if (state.writing) begin
        if (!link.dataMask) begin
          next_state.mem = link.dataIn; // see R3
        end
        next_state.writeLeft = state.writeLeft - 4'h1;
        next_state.writing = state.writeLeft != 4'h1;
      end
      if (cmdValid) begin
        case (link.command)
          CMD_READ, CMD_READ_AP: begin
            next_state.readLeft = BURST_LEN;
            next_state.writing = 1'b0;
          end
          CMD_WRITE, CMD_WRITE_AP: begin
            // First word comes with the command itself.
            if (!link.dataMask) begin
              next_state.mem = link.dataIn; // see R3, R4
            end
            next_state.writing = 1'b1;
            next_state.writeLeft = BURST_LEN - 4'h1;
            next_state.readLeft = 4'h0;
          end
          CMD_PRECHARGE, CMD_BURST_STOP: begin
            // Words already issued still drain, giving the last word
            // at CL-1 and the float at CL.
            next_state.readLeft = 4'h0; // see R6, R7, R8, R9
            next_state.writing = 1'b0;
          end
          default: begin
          end
        endcase
      end
      lastStage = (casLatency == CAS_LAT_3) ? state.pipe[1]
                                            : state.pipe[0];
      next_state.dOut = state.mem;
      // Mask two cycles old floats the word of this cycle.
      next_state.dOe = lastStage && !state.maskPipe[1]; // see R2, R6, R8
    end else begin
      lastStage = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '{clkRun: 1'b1, mem: MEM_RESET, readLeft: RD_PIPE_RESET,
                 issue: RD_PIPE_RESET, pipe: RD_PIPE_RESET,
                 maskPipe: 2'h0, dOut: MEM_RESET, dOe: 1'b0,
                 writing: 1'b0, writeLeft: 4'h0};
    end else begin
      state <= next_state;
    end
  end

  assign link.memDataOut = state.dOut;
  assign link.memDataOe  = state.dOe;
  assign clockRunning    = state.clkRun;
  assign storedWord      = state.mem;
  assign burstActive     = state.dOe;
endmodule : sdram_memory_end
`default_nettype wire

// [shared/sdram_lat_pkg.sv]
// Purpose: Shared constants and types for the SDRAM command latency ends.
// Assumes: One clock, 125 MHz, shared by memory and controller.
// Notes:   All latencies are whole clock counts.
package sdram_lat_pkg;
  localparam int          DATA_W        = 16;
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          PRE_TO_ACT_PS = 15000;
  // Nanosecond timing rounded up to whole cycles.
  localparam int          PRE_TO_ACT_CYC =
    (PRE_TO_ACT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          CKE_LAT       = 1;
  localparam int          RD_MASK_LAT   = 2;
  localparam int          WR_MASK_LAT   = 0;
  localparam logic [3:0]  BURST_LEN     = 4'h4;
  localparam logic [1:0]  CAS_LAT_2     = 2'h2;
  localparam logic [1:0]  CAS_LAT_3     = 2'h3;
  localparam logic [DATA_W-1:0] MEM_RESET = 16'h0000;
  localparam logic [3:0]  RD_PIPE_RESET = 4'h0;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_READ, CMD_WRITE, CMD_READ_AP, CMD_WRITE_AP,
    CMD_PRECHARGE, CMD_BURST_STOP, CMD_ACTIVATE
  } cmd_t;
endpackage : sdram_lat_pkg

// [shared/sdram_link_if.sv]
// Purpose: Command, mask and data wires between controller and memory.
// Assumes: Data bus is two-way; each end has its own output enable.
// Notes:   The resolved data level is worked out here from the enables.
`timescale 1ns/100ps
`default_nettype none
interface sdram_link_if;
  import sdram_lat_pkg::*;
  logic              clkEnable;
  logic              chipSelectN;
  cmd_t              command;
  logic              dataMask;
  logic [DATA_W-1:0] ctrlDataOut;
  logic              ctrlDataOe;
  logic [DATA_W-1:0] memDataOut;
  logic              memDataOe;
  logic [DATA_W-1:0] dataIn;

  assign dataIn = memDataOe ? memDataOut :
                  (ctrlDataOe ? ctrlDataOut : '0);

  modport memory (input clkEnable, chipSelectN, command, dataMask,
                  dataIn, output memDataOut, memDataOe);
  modport controller (output clkEnable, chipSelectN, command, dataMask,
                      ctrlDataOut, ctrlDataOe, input dataIn);
endinterface : sdram_link_if
`default_nettype wire

// [logic/sdram_controller_end.sv]
// Purpose: Controller end: issues commands, write data and gaps.
// Assumes: User requests are one-cycle pulses when ready is high.
// Notes:   Auto-precharge gaps block all requests until they elapse.
`timescale 1ns/100ps
`default_nettype none
module sdram_controller_end
  import sdram_lat_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              reqValid,
  input  wire cmd_t              reqCommand,
  input  wire logic [DATA_W-1:0] reqData,
  input  wire logic              reqMask,
  input  wire logic              reqClkEnable,
  sdram_link_if.controller       link,
  output logic                   reqReady,
  output logic [DATA_W-1:0]      readData
);
  typedef struct packed {
    logic              cke;
    logic              csN;
    cmd_t              cmd;
    logic              dqm;
    logic [DATA_W-1:0] dOut;
    logic              dOe;
    logic [7:0]        gap;
    logic [DATA_W-1:0] rData;
    logic [3:0]        wrLeft;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.cke = reqClkEnable;
    next_state.csN = 1'b1;
    next_state.cmd = CMD_NOP;
    next_state.dqm = reqMask;
    next_state.rData = link.dataIn;
    if (state.gap != 8'h00) begin
      next_state.gap = state.gap - 8'h01;
    end
    if (state.wrLeft != 4'h0) begin
      next_state.wrLeft = state.wrLeft - 4'h1;
    end
    if (reqValid && state.gap == 8'h00) begin
      next_state.csN = 1'b0;
      next_state.cmd = reqCommand;
      // Write data rides with the write command.
      next_state.dOe = (reqCommand == CMD_WRITE) ||
                       (reqCommand == CMD_WRITE_AP); // see R4
      // The word is held for the whole burst so later burst words do not
      // pick up an undriven bus; any other command cuts the burst.
      next_state.wrLeft = 4'h0;
      if (next_state.dOe) begin
        next_state.dOut = reqData;
        next_state.wrLeft = BURST_LEN - 4'h1;
      end
      if (reqCommand == CMD_READ_AP) begin
        next_state.gap = 8'(BURST_LEN) + 8'(PRE_TO_ACT_CYC); // see R10, R12
      end else if (reqCommand == CMD_WRITE_AP) begin
        next_state.gap = 8'(BURST_LEN) + 8'h01
                         + 8'(PRE_TO_ACT_CYC); // see R11, R12
      end
    end else begin
      next_state.dOe = state.wrLeft != 4'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= '{cke: 1'b1, csN: 1'b1, cmd: CMD_NOP, dqm: 1'b0,
                 dOut: MEM_RESET, dOe: 1'b0, gap: 8'h00,
                 rData: MEM_RESET, wrLeft: 4'h0};
    end else begin
      state <= next_state;
    end
  end

  assign link.clkEnable   = state.cke;
  assign link.chipSelectN = state.csN;
  assign link.command     = state.cmd;
  assign link.dataMask    = state.dqm;
  assign link.ctrlDataOut = state.dOut;
  assign link.ctrlDataOe  = state.dOe;
  assign reqReady         = (state.gap == 8'h00);
  assign readData         = state.rData;
endmodule : sdram_controller_end
`default_nettype wire

// [bench/sdram_link_properties.sv]
// Purpose: Timing properties of the link between the two ends.
// Assumes: One clock domain; casLatency only changes under reset.
// Notes:   Sees the control, mask and enable wires of the interface and the casLatency strap.
`timescale 1ns/100ps
`default_nettype none
module sdram_link_properties
  import sdram_lat_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic [1:0] casLatency,
  input wire logic       clkEnable,
  input wire logic       chipSelectN,
  input wire cmd_t       command,
  input wire logic       dataMask,
  input wire logic       ctrlDataOe,
  input wire logic       memDataOe
);
  logic run;
  logic take;
  logic stop;
  // A command only lands when the clock ran at the previous edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      run <= 1'b1;
    else
      run <= clkEnable;
  end
  assign take = run && !chipSelectN;
  assign stop = take &&
    (command == CMD_PRECHARGE || command == CMD_BURST_STOP);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_wr_data_with_cmd: assert property (
    !chipSelectN && (command == CMD_WRITE || command == CMD_WRITE_AP)
    |-> ctrlDataOe) else $error("write data not driven with command");
  a_rd_mask_float: assert property (
    dataMask |-> ##3 !memDataOe) else $error("masked word was driven");
  a_read_starts: assert property (
    take && command == CMD_READ |-> ##[3:5] memDataOe)
    else $error("read burst did not start");
  a_stop_float_cl2: assert property (
    stop && casLatency == CAS_LAT_2 |-> ##3 !memDataOe [*2])
    else $error("outputs not floated at latency two");
  a_stop_float_cl3: assert property (
    stop && casLatency == CAS_LAT_3 |-> ##4 !memDataOe [*2])
    else $error("outputs not floated at latency three");
  a_rdap_gap: assert property (
    take && command == CMD_READ_AP |=> !(take && command == CMD_ACTIVATE)
    [*5]) else $error("activate too soon after read precharge");
  a_wrap_gap: assert property (
    take && command == CMD_WRITE_AP |=> !(take && command == CMD_ACTIVATE)
    [*6]) else $error("activate too soon after write precharge");
  a_suspend_hold: assert property (
    !clkEnable |-> ##2 $stable(memDataOe))
    else $error("output moved while clock suspended");
  c_stop: cover property (stop);
  c_read_ap: cover property (take && command == CMD_READ_AP);
  c_burst: cover property ($rose(memDataOe));
endmodule : sdram_link_properties
`default_nettype wire

// [bench/test_sdram_command_latency_rules.sv]
// Purpose: Drives both ends through writes, reads, cuts and gaps.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Cut counts are fixed; the cut lands two edges after the read.
`timescale 1ns/100ps
`default_nettype none
module test_sdram_command_latency_rules;
  import sdram_lat_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [1:0]        casLatency = CAS_LAT_3;
  logic              reqValid = 1'b0;
  cmd_t              reqCommand = CMD_NOP;
  logic [DATA_W-1:0] reqData = 16'h0000;
  logic              reqMask = 1'b0;
  logic              reqClkEnable = 1'b1;
  logic              clockRunning, burstActive, reqReady;
  logic [DATA_W-1:0] storedWord, readData;
  int                errors = 0, comparisons = 0, cycles = 0, lat, n;
  sdram_link_if link ();
  sdram_memory_end i_sdram_memory_end (.ref_clk, .rst, .casLatency,
    .link(link.memory), .clockRunning, .storedWord, .burstActive);
  sdram_controller_end i_sdram_controller_end (.ref_clk, .rst, .reqValid,
    .reqCommand, .reqData, .reqMask, .reqClkEnable,
    .link(link.controller), .reqReady, .readData);
  sdram_link_properties i_props (.ref_clk, .rst, .casLatency,
    .clkEnable(link.clkEnable), .chipSelectN(link.chipSelectN),
    .command(link.command), .dataMask(link.dataMask),
    .ctrlDataOe(link.ctrlDataOe), .memDataOe(link.memDataOe));
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic issue(input cmd_t c, input logic [DATA_W-1:0] d);
    for (int i = 0; i < 20 && reqReady !== 1'b1; i++) tick(1);
    reqCommand = c;
    reqData = d;
    reqValid = 1'b1;
    tick(1);
    reqValid = 1'b0;
  endtask : issue
  task automatic words(output int cnt);
    cnt = 0;
    repeat (12) begin
      if (burstActive === 1'b1) cnt++;
      tick(1);
    end
  endtask : words
  initial begin : main
    for (int j = 2; j <= 3; j++) begin
      rst = 1'b1;
      casLatency = 2'(j);
      tick(5);
      rst = 1'b0;
      issue(CMD_WRITE, 16'h3C00 + 16'(j));
      tick(2);
      check("storedWord", 16'h3C00 + 16'(j), storedWord);
      reqMask = 1'b1;
      issue(CMD_WRITE, 16'h0F0F);
      tick(3);
      reqMask = 1'b0;
      tick(1);
      check("maskedWrite", 16'h3C00 + 16'(j), storedWord);
      issue(CMD_READ, 16'h0000);
      for (lat = 0; lat < 20 && burstActive !== 1'b1; lat++) tick(1);
      tick(1);
      check("readData", 16'h3C00 + 16'(j), readData);
      words(n);
      check("burstWords", 16'(BURST_LEN) - 16'h1, 16'(n));
      issue(CMD_READ, 16'h0000);
      // Mask lands one edge after the read; it floats the first
      // word that is still due two edges after that.
      reqMask = 1'b1;
      tick(1);
      reqMask = 1'b0;
      words(n);
      check("maskedWords", 16'(BURST_LEN) - 16'h1, 16'(n));
      for (int k = 0; k < 2; k++) begin
        issue(CMD_READ, 16'h0000);
        tick(1);
        issue(k ? CMD_BURST_STOP : CMD_PRECHARGE, 16'h0000);
        words(n);
        // The cut lands two edges after the read, so two words remain.
        check("cutWords", 16'h0002, 16'(n));
      end
      for (int k = 0; k < 2; k++) begin
        issue(k ? CMD_WRITE_AP : CMD_READ_AP, 16'h0000);
        for (n = 0; n < 20 && reqReady !== 1'b1; n++) tick(1);
        check("apGap", 16'(BURST_LEN + k + (15 + 7) / 8), 16'(n));
        issue(CMD_ACTIVATE, 16'h0000);
        tick(12);
      end
    end
    reqClkEnable = 1'b0;
    tick(3);
    check("clockRunning", 16'h0000, 16'(clockRunning));
    issue(CMD_WRITE, 16'h7E81);
    tick(2);
    check("suspendedWrite", 16'h0000, storedWord);
    reqClkEnable = 1'b1;
    tick(3);
    check("clockRunning", 16'h0001, 16'(clockRunning));
    stop_test();
  end
endmodule : test_sdram_command_latency_rules
`default_nettype wire
